//--- common/data_space_defs.vh
// Constants for the data space decoder
`ifndef DATA_SPACE_DEFS_VH
`define DATA_SPACE_DEFS_VH
`define DS_REG_END     16'h0020
`define DS_STDIO_END   16'h0060
`define DS_EXTIO_END   16'h0100
`define DS_SRAM_END    16'h1100
`define DS_IO_OFFSET   16'h0020
`define DS_BITIO_LAST  6'h1f
`define DS_PTR_X       5'h1a
`define DS_PTR_Y       5'h1c
`define DS_PTR_Z       5'h1e
`define DS_DISP_MAX    6'h3f
`define DS_EE_RD_STALL 3'h4
`define DS_EE_WR_STALL 3'h2
`define DS_EE_AW       11
`define DS_EE_WR_CYC   32'd412000
`define DS_GPIO0_ADR   6'h1e
`define DS_GPIO1_ADR   6'h2a
`define DS_GPIO2_ADR   6'h2b
`define DS_EECR_ADR    6'h1f
`define DS_EEDR_ADR    6'h20
`define DS_EEARL_ADR   6'h21
`define DS_EEARH_ADR   6'h22
`define DS_FLAG_ADR    6'h15
`define DS_MODE_DIRECT 3'h0
`define DS_MODE_DISP   3'h1
`define DS_MODE_IND    3'h2
`define DS_MODE_PREDEC 3'h3
`define DS_MODE_POSTIN 3'h4
`define DS_OP_NONE     3'h0
`define DS_OP_LOAD     3'h1
`define DS_OP_STORE    3'h2
`define DS_OP_IOIN     3'h3
`define DS_OP_IOOUT    3'h4
`define DS_OP_BITSET   3'h5
`define DS_OP_BITCLR   3'h6
`define DS_OP_BITTEST  3'h7
`endif

//--- hdl/ee_write_timer.v
// Self-timed EEPROM write countdown
`timescale 1ns/1ps
`include "data_space_defs.vh"
module ee_write_timer #(
	parameter WR_CYCLES = `DS_EE_WR_CYC
) (
	// Clock and power-on reset only
	input  wire        sys_clk,
	input  wire        porRst,
	// Control
	input  wire        start,
	output reg         busy_r
);
	reg [31:0] count_r;
	// Not cleared by the CPU reset, so a write in progress finishes
	always @(posedge sys_clk or posedge porRst) begin
		if (porRst) begin
			count_r <= 32'h0;
			busy_r  <= 1'b0;
		end else if (start && !busy_r) begin
			count_r <= WR_CYCLES;
			busy_r  <= 1'b1;
		end else if (busy_r) begin
			count_r <= count_r - 32'h1;
			if (count_r == 32'h1)
				busy_r <= 1'b0;
		end
	end
endmodule

//--- hdl/data_space_decoder.v
// Data space decoder with I/O, SRAM and EEPROM access control
// Summary of operation
// - Registers at 0..31, standard I/O next 64, extended I/O 160, SRAM 4096.
// - Decode 4,352 byte locations from address zero.
// - Extended I/O 0x60..0xFF reached only by load and store.
// - Port in/out use I/O 0x00..0x3F; data address is I/O plus 0x20.
// - Bit set and clear only on I/O 0x00..0x1F.
// - Skip-on-bit instructions test one bit of low I/O registers.
// - Bit set and clear change only the addressed bit.
// - Some status flags clear when written with one.
// - SRAM access completes in two clock cycles.
// - Direct addressing reaches the whole data space.
// - Displacement mode adds up to 63 to Y or Z, or to X when the pointer select is 3.
// - X, Y and Z pointers are register pairs R26..R31.
// - Pre-decrement before use, post-increment after, written back.
// - All locations reachable through all five addressing modes.
// - EEPROM read stalls CPU four cycles.
// - EEPROM write stalls CPU two cycles.
// - EEPROM is a separate 2K byte space with registers in I/O.
// - EEPROM writes self-timed; busy bit shows completion.
// - Reset during an EEPROM write lets the write finish.
// - Three plain general purpose I/O registers; low one bit-accessible.
// - Program memory is 16-bit words with a word program counter.
`timescale 1ns/1ps
`include "data_space_defs.vh"
module data_space_decoder #(
	parameter EE_WR_CYCLES = `DS_EE_WR_CYC,
	parameter PC_WIDTH     = 16
) (
	// Clock and resets
	input  wire                  sys_clk,
	input  wire                  rst,
	input  wire                  porRst,
	// CPU request
	input  wire                  reqValid,
	input  wire [2:0]            reqOp,
	input  wire [2:0]            reqMode,
	input  wire [15:0]           reqAddr,
	input  wire [1:0]            reqPtrSel,
	input  wire [5:0]            reqDisp,
	input  wire [2:0]            reqBit,
	input  wire [7:0]            reqWdata,
	// Hardware status flag event
	input  wire                  flagEvent,
	// Program counter for program memory fetch
	input  wire [PC_WIDTH-1:0]   pcWord,
	// Answers
	output reg                   ackValid_r,
	output reg  [7:0]            ackRdata_r,
	output reg                   ackBit_r,
	output reg                   ackErr_r,
	output reg                   cpuStall_r,
	output reg  [15:0]           effAddr_r,
	output reg  [PC_WIDTH-1:0]   progAddr_r,
	output reg                   eeBusy_r
);
	reg [7:0] regFile [0:31];
	reg [7:0] sram [0:4095];
	reg [7:0] eeMem [0:2047];
	reg [7:0] gpio0_r, gpio1_r, gpio2_r, flag_r, eeData_r;
	reg [11:0] eeAddr_r;
	reg [1:0] eeCtl_r;
	reg [2:0] stallCnt_r;
	reg       sramPend_r;
	reg [7:0] sramData_r;
	reg [15:0] ptr, base, addr, ptrNew;
	reg [4:0]  ptrIdx;
	reg        writeBack;
	reg        isWrite, isBit, isIo, err;
	reg [5:0]  ioAdr;
	reg [7:0]  ioOld, ioNew, wv;
	reg [15:0] ioSub;
	wire       wrBusy;
	wire       eeStart;
	wire       busy = sramPend_r || stallCnt_r != 3'h0;
	wire       take = reqValid && !busy;
	integer    i;

	ee_write_timer #(.WR_CYCLES(EE_WR_CYCLES)) u_timer (
		.sys_clk (sys_clk),
		.porRst  (porRst),
		.start   (eeStart),
		.busy_r  (wrBusy)
	);

	// Address generation
	always @* begin
		ptrIdx = `DS_PTR_X;
		case (reqPtrSel)
			2'h1: ptrIdx = `DS_PTR_Y;
			2'h2: ptrIdx = `DS_PTR_Z;
			default: ptrIdx = `DS_PTR_X;
		endcase
		ptr = {regFile[ptrIdx + 5'h1], regFile[ptrIdx]};
		base = ptr;
		ptrNew = ptr;
		writeBack = 1'b0;
		err = 1'b0;
		case (reqMode)
			`DS_MODE_DIRECT: base = reqAddr;
			`DS_MODE_DISP: begin
				base = ptr + {10'h0, reqDisp & `DS_DISP_MAX};
				if (reqPtrSel == 2'h0)
					err = 1'b1;
			end
			`DS_MODE_IND: base = ptr;
			`DS_MODE_PREDEC: begin
				ptrNew = ptr - 16'h1;
				base = ptrNew;
				writeBack = 1'b1;
			end
			`DS_MODE_POSTIN: begin
				ptrNew = ptr + 16'h1;
				writeBack = 1'b1;
			end
			default: err = 1'b1;
		endcase
		isIo = reqOp >= `DS_OP_IOIN;
		isBit = reqOp >= `DS_OP_BITSET;
		isWrite = reqOp == `DS_OP_STORE || reqOp == `DS_OP_IOOUT ||
			reqOp == `DS_OP_BITSET || reqOp == `DS_OP_BITCLR;
		ioAdr = reqAddr[5:0];
		ioSub = base - `DS_IO_OFFSET;
		if (isIo) begin
			addr = {10'h0, ioAdr} + `DS_IO_OFFSET;
			writeBack = 1'b0;
			if (reqAddr[15:6] != 10'h0)
				err = 1'b1;
			if (isBit && ioAdr > `DS_BITIO_LAST)
				err = 1'b1;
		end else begin
			addr = base;
			ioAdr = ioSub[5:0];
		end
		if (addr >= `DS_SRAM_END)
			err = 1'b1;
		if (reqOp == `DS_OP_NONE)
			err = 1'b1;
	end

	// I/O register read
	always @* begin
		ioOld = 8'h00;
		case (ioAdr)
			`DS_GPIO0_ADR: ioOld = gpio0_r;
			`DS_GPIO1_ADR: ioOld = gpio1_r;
			`DS_GPIO2_ADR: ioOld = gpio2_r;
			`DS_FLAG_ADR: ioOld = flag_r;
			`DS_EECR_ADR: ioOld = {6'h0, wrBusy, 1'b0};
			`DS_EEDR_ADR: ioOld = eeData_r;
			`DS_EEARL_ADR: ioOld = eeAddr_r[7:0];
			`DS_EEARH_ADR: ioOld = {4'h0, eeAddr_r[11:8]};
			default: ioOld = 8'h00;
		endcase
		wv = reqWdata;
		ioNew = reqWdata;
		if (reqOp == `DS_OP_BITSET) begin
			wv = 8'h01 << reqBit;
			ioNew = ioOld | wv;
		end else if (reqOp == `DS_OP_BITCLR) begin
			wv = 8'h00;
			ioNew = ioOld & ~(8'h01 << reqBit);
		end
	end

	wire ioHit = addr >= `DS_REG_END && addr < `DS_EXTIO_END;
	wire ioWr = take && !err && isWrite && ioHit;
	wire eeCtlWr = ioWr && ioAdr == `DS_EECR_ADR;
	// SRAM index relative to the start of SRAM
	wire [15:0] sramOff = addr - `DS_EXTIO_END;
	assign eeStart = eeCtlWr && ioNew[1] && eeCtl_r[1] && !wrBusy;
	wire eeRead = eeCtlWr && ioNew[0] && !wrBusy;
	wire [`DS_EE_AW-1:0] eeIdx = eeAddr_r[`DS_EE_AW-1:0];

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 32; i = i + 1)
				regFile[i] <= 8'h00;
			gpio0_r <= 8'h00;
			gpio1_r <= 8'h00;
			gpio2_r <= 8'h00;
			flag_r <= 8'h00;
			eeData_r <= 8'h00;
			eeAddr_r <= 12'h000;
			eeCtl_r <= 2'h0;
			stallCnt_r <= 3'h0;
			sramPend_r <= 1'b0;
			sramData_r <= 8'h00;
			ackValid_r <= 1'b0;
			ackRdata_r <= 8'h00;
			ackBit_r <= 1'b0;
			ackErr_r <= 1'b0;
			cpuStall_r <= 1'b0;
			effAddr_r <= 16'h0000;
			progAddr_r <= {PC_WIDTH{1'b0}};
			eeBusy_r <= 1'b0;
		end else begin
			progAddr_r <= pcWord;
			eeBusy_r <= wrBusy;
			ackValid_r <= 1'b0;
			ackErr_r <= 1'b0;
			if (eeCtl_r[1])
				eeCtl_r <= eeCtl_r - 2'h1;
			// Hardware set wins over software clear
			flag_r <= flagEvent ? 8'h01 | flag_r : flag_r;
			if (stallCnt_r != 3'h0)
				stallCnt_r <= stallCnt_r - 3'h1;
			if (sramPend_r) begin
				sramPend_r <= 1'b0;
				ackValid_r <= 1'b1;
				ackRdata_r <= sramData_r;
			end
			cpuStall_r <= (stallCnt_r > 3'h1) || eeStart || eeRead;
			if (take) begin
				effAddr_r <= addr;
				if (writeBack && !err) begin
					regFile[ptrIdx] <= ptrNew[7:0];
					regFile[ptrIdx + 5'h1] <= ptrNew[15:8];
				end
				if (err) begin
					ackValid_r <= 1'b1;
					ackErr_r <= 1'b1;
				end else if (addr < `DS_REG_END) begin
					ackValid_r <= 1'b1;
					ackRdata_r <= regFile[addr[4:0]];
					if (isWrite)
						regFile[addr[4:0]] <= reqWdata;
				end else if (ioHit) begin
					ackValid_r <= 1'b1;
					ackRdata_r <= ioOld;
					ackBit_r <= ioOld[reqBit];
					if (isWrite) begin
						case (ioAdr)
							`DS_GPIO0_ADR: gpio0_r <= ioNew;
							`DS_GPIO1_ADR: gpio1_r <= ioNew;
							`DS_GPIO2_ADR: gpio2_r <= ioNew;
							`DS_FLAG_ADR:
								flag_r <= (flag_r & ~wv) |
									{7'h0, flagEvent};
							`DS_EECR_ADR:
								if (ioNew[2] && !ioNew[1])
									eeCtl_r <= 2'h3;
							`DS_EEDR_ADR: eeData_r <= ioNew;
							`DS_EEARL_ADR:
								if (!wrBusy)
									eeAddr_r[7:0] <= ioNew;
							`DS_EEARH_ADR:
								if (!wrBusy)
									eeAddr_r[11:8] <= ioNew[3:0];
							default: ;
						endcase
					end
				end else begin
					sramPend_r <= 1'b1;
					sramData_r <= sram[sramOff[11:0]];
					if (isWrite)
						sram[sramOff[11:0]] <= reqWdata;
				end
				if (eeRead) begin
					eeData_r <= eeMem[eeIdx];
					stallCnt_r <= `DS_EE_RD_STALL;
				end
				if (eeStart) begin
					eeMem[eeIdx] <= eeData_r;
					eeCtl_r <= 2'h0;
					stallCnt_r <= `DS_EE_WR_STALL;
				end
			end
		end
	end
endmodule

//--- sim/data_space_decoder_chk.sv
// Checker for the data space decoder
`timescale 1ns/1ps
`include "data_space_defs.vh"
module data_space_decoder_chk #(
	parameter EE_WR_CYCLES = 20,
	parameter PC_WIDTH     = 16
) (
	// Clock, reset and request
	input wire                sys_clk,
	input wire                rst,
	input wire                reqValid,
	input wire [2:0]          reqOp,
	input wire [2:0]          reqMode,
	input wire [15:0]         reqAddr,
	input wire [1:0]          reqPtrSel,
	input wire [2:0]          reqBit,
	input wire [PC_WIDTH-1:0] pcWord,
	// Answers
	input wire                ackValid_r,
	input wire                ackErr_r,
	input wire                cpuStall_r,
	input wire [PC_WIDTH-1:0] progAddr_r,
	input wire                eeBusy_r
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire       tk = reqValid && !cpuStall_r;
	wire       ld = tk && reqOp == `DS_OP_LOAD;
	wire       dr = ld && reqMode == `DS_MODE_DIRECT;
	wire       bo = tk && reqOp >= `DS_OP_BITSET;
	reg [31:0] bsy_r;
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			bsy_r <= 32'h0;
		else
			bsy_r <= eeBusy_r ? bsy_r + 32'h1 : 32'h0;
	end
	chk_err_ack: assert property (ackErr_r |-> ackValid_r)
		else $error("error without answer");
	chk_top_end: assert property (dr && reqAddr >= `DS_SRAM_END |=> ackErr_r)
		else $error("load past end accepted");
	chk_reg_lat: assert property (dr && reqAddr < `DS_REG_END |=> ackValid_r)
		else $error("register load late");
	chk_sram_lat: assert property (dr && reqAddr >= `DS_EXTIO_END
		&& reqAddr < `DS_SRAM_END |=> !ackValid_r ##1 ackValid_r && !ackErr_r)
		else $error("sram load timing");
	chk_io_range: assert property (tk && reqAddr > 16'h3f
		&& (reqOp == `DS_OP_IOIN || reqOp == `DS_OP_IOOUT) |=> ackErr_r)
		else $error("io op above 3f accepted");
	chk_bit_range: assert property (bo && reqAddr > 16'h1f |=> ackErr_r)
		else $error("bit op above 1f accepted");
	chk_disp_x: assert property (ld && reqMode == `DS_MODE_DISP
		&& reqPtrSel == 2'h0 |=> ackErr_r)
		else $error("displacement on X accepted");
	chk_rd_stall: assert property (bo && reqOp == `DS_OP_BITSET
		&& reqAddr == 16'h1f && reqBit == 3'h0 && !eeBusy_r
		|=> cpuStall_r [*4] ##1 !cpuStall_r)
		else $error("eeprom read stall length");
	chk_pc_pass: assert property (!$past(rst)
		|-> progAddr_r == $past(pcWord))
		else $error("program address not passed");
	chk_busy_end: assert property (bsy_r <= EE_WR_CYCLES + 4)
		else $error("eeprom write never ends");
	cover property (dr && reqAddr >= `DS_EXTIO_END);
	cover property ($rose(eeBusy_r));
	cover property ($fell(cpuStall_r));
endmodule
bind data_space_decoder data_space_decoder_chk #(
	.EE_WR_CYCLES(EE_WR_CYCLES), .PC_WIDTH(PC_WIDTH)
) u_data_space_decoder_chk (.sys_clk, .rst, .reqValid, .reqOp, .reqMode,
	.reqAddr, .reqPtrSel, .reqBit, .pcWord, .ackValid_r, .ackErr_r,
	.cpuStall_r, .progAddr_r, .eeBusy_r);

//--- sim/cpu_model.sv
// CPU core model issuing data space requests
`timescale 1ns/1ps
module cpu_model (
	// Clock and answers
	input wire        sys_clk,
	input wire        ackValid_r,
	input wire        cpuStall_r,
	// Request
	output reg        reqValid,
	output reg [2:0]  reqOp,
	output reg [2:0]  reqMode,
	output reg [15:0] reqAddr,
	output reg [1:0]  reqPtrSel,
	output reg [5:0]  reqDisp,
	output reg [2:0]  reqBit,
	output reg [7:0]  reqWdata
);
	integer i;
	initial begin
		{reqValid, reqOp, reqMode, reqAddr} = 23'h0;
		{reqPtrSel, reqDisp, reqBit, reqWdata} = 19'h0;
	end
	// One request, then wait out answer and stall
	task access(input [2:0] o, m, input [15:0] a, input [1:0] p,
		input [5:0] d, input [2:0] b, input [7:0] w);
		begin
			@(posedge sys_clk);
			reqValid <= 1'b1;
			{reqOp, reqMode, reqAddr, reqPtrSel} <= {o, m, a, p};
			{reqDisp, reqBit, reqWdata} <= {d, b, w};
			@(posedge sys_clk);
			reqValid <= 1'b0;
			// Released address and write data must not keep their value
			{reqAddr, reqWdata} <= {~a, ~w};
			#1;
			for (i = 0; i < 8 && ackValid_r !== 1'b1; i = i + 1)
				@(posedge sys_clk) #1;
			for (i = 0; i < 9 && cpuStall_r === 1'b1; i = i + 1)
				@(posedge sys_clk) #1;
		end
	endtask
endmodule

//--- sim/data_space_decoder_tb.sv
// Self-checking bench for the data space decoder
`timescale 1ns/1ps
`include "data_space_defs.vh"
module data_space_decoder_tb;
	reg         sys_clk = 1'b0;
	reg         rst = 1'b1;
	reg         porRst = 1'b1;
	reg         flagEvent = 1'b0;
	reg  [15:0] pcWord = 16'h0;
	wire        reqValid, ackValid_r, ackBit_r, ackErr_r, cpuStall_r, eeBusy_r;
	wire [2:0]  reqOp, reqMode, reqBit;
	wire [15:0] reqAddr, effAddr_r, progAddr_r;
	wire [1:0]  reqPtrSel;
	wire [5:0]  reqDisp;
	wire [7:0]  reqWdata, ackRdata_r;
	integer     n_fail = 0;
	integer     n_checks = 0;
	integer     seed = 32'h1d5e;
	integer     k;
	reg  [7:0]  v;
	reg  [10:0] e;
	reg  [10:0] expq[$];
	reg  [15:0] adr[0:4] = '{16'h0, 16'h1f, 16'h3e, 16'h100, 16'h10ff};
	reg  [7:0]  pv[0:5] = '{8'h0, 8'h1, 8'h0, 8'h1, 8'hff, 8'h10};
	data_space_decoder #(.EE_WR_CYCLES(20)) u_data_space_decoder (.sys_clk,
		.rst, .porRst, .reqValid, .reqOp, .reqMode, .reqAddr, .reqPtrSel,
		.reqDisp, .reqBit, .reqWdata, .flagEvent, .pcWord, .ackValid_r,
		.ackRdata_r, .ackBit_r, .ackErr_r, .cpuStall_r, .effAddr_r,
		.progAddr_r, .eeBusy_r);
	cpu_model u_cpu_model (.sys_clk, .ackValid_r, .cpuStall_r, .reqValid,
		.reqOp, .reqMode, .reqAddr, .reqPtrSel, .reqDisp, .reqBit, .reqWdata);
	task cmp8(input [7:0] g, x);
		begin
			n_checks = n_checks + 1;
			if (g !== x) begin
				n_fail = n_fail + 1;
				$display("unexpected at %0t: got %h want %h", $time, g, x);
			end
		end
	endtask
	task final_report;
		begin
			if (expq.size() != 0)
				n_fail = n_fail + 1;
			if (n_fail == 0 && n_checks > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Note {error, data used, bit used, data} then issue
	task acc(input [2:0] o, m, input [15:0] a, input [1:0] p,
		input [5:0] d, input [2:0] b, input [7:0] w, input [10:0] x);
		begin
			expq.push_back(x);
			u_cpu_model.access(o, m, a, p, d, b, w);
		end
	endtask
	task q(input [2:0] o, input [15:0] a, input [2:0] b, input [10:0] x);
		acc(o, `DS_MODE_DIRECT, a, 2'h0, 6'h0, b, v, x);
	endtask
	task st(input [15:0] a, input [7:0] w);
		acc(`DS_OP_STORE, `DS_MODE_DIRECT, a, 2'h0, 6'h0, 3'h0, w, 11'h0);
	endtask
	task ld(input [15:0] a, input [7:0] x);
		q(`DS_OP_LOAD, a, 3'h0, {3'h2, x});
	endtask
	task p(input [2:0] o, m, input [1:0] s, input [5:0] d, input [10:0] x);
		acc(o, m, 16'h0, s, d, 3'h0, v, x);
	endtask
	initial forever #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		pcWord <= 16'($random(seed));
	always @(posedge sys_clk) begin
		if (ackValid_r === 1'b1) begin
			e = expq.size() ? expq.pop_front() : 11'h7ff;
			cmp8({7'h0, ackErr_r}, {7'h0, e[10]});
			if (e[9])
				cmp8(ackRdata_r, e[7:0]);
			if (e[8])
				cmp8({7'h0, ackBit_r}, e[7:0]);
		end
	end
	initial begin
		#100000;
		n_fail = n_fail + 1;
		final_report;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rst <= 1'b0;
		porRst <= 1'b0;
		for (k = 0; k < 5; k = k + 1) begin
			v = 8'($random(seed));
			st(adr[k], v);
			ld(adr[k], v);
		end
		q(`DS_OP_LOAD, `DS_SRAM_END, 3'h0, 11'h400);
		q(`DS_OP_STORE, `DS_SRAM_END, 3'h0, 11'h400);
		q(`DS_OP_IOOUT, 16'h40, 3'h0, 11'h400);
		q(`DS_OP_BITSET, 16'h2a, 3'h0, 11'h400);
		q(`DS_OP_IOOUT, 16'h2a, 3'h0, 11'h0);
		ld(16'h4a, v);
		st(16'h4b, ~v);
		q(`DS_OP_IOIN, 16'h2b, 3'h0, {3'h2, ~v});
		st(16'h3e, 8'h81);
		q(`DS_OP_BITSET, 16'h1e, 3'h5, 11'h0);
		q(`DS_OP_BITTEST, 16'h1e, 3'h5, 11'h101);
		q(`DS_OP_BITCLR, 16'h1e, 3'h7, 11'h0);
		q(`DS_OP_BITTEST, 16'h1e, 3'h7, 11'h100);
		ld(16'h3e, 8'h21);
		@(posedge sys_clk) flagEvent <= 1'b1;
		@(posedge sys_clk) flagEvent <= 1'b0;
		q(`DS_OP_BITCLR, 16'h15, 3'h1, 11'h0);
		q(`DS_OP_BITTEST, 16'h15, 3'h0, 11'h101);
		st(16'h35, 8'h01);
		q(`DS_OP_BITTEST, 16'h15, 3'h0, 11'h100);
		for (k = 0; k < 6; k = k + 1)
			st(16'(16'h1a + k), pv[k]);
		p(`DS_OP_STORE, `DS_MODE_POSTIN, 2'h0, 6'h0, 11'h0);
		ld(16'h100, v);
		ld(16'h1a, 8'h01);
		v = ~v;
		p(`DS_OP_STORE, `DS_MODE_PREDEC, 2'h0, 6'h0, 11'h0);
		ld(16'h100, v);
		ld(16'h1a, 8'h00);
		st(16'h13f, ~v);
		p(`DS_OP_LOAD, `DS_MODE_DISP, 2'h1, 6'h3f, {3'h2, ~v});
		cmp8(effAddr_r[15:8], 8'h01);
		cmp8(effAddr_r[7:0], 8'h3f);
		p(`DS_OP_STORE, `DS_MODE_IND, 2'h2, 6'h0, 11'h0);
		ld(16'h10ff, v);
		p(`DS_OP_LOAD, `DS_MODE_DISP, 2'h0, 6'h1, 11'h400);
		q(`DS_OP_BITSET, 16'h1f, 3'h0, 11'h0);
		q(`DS_OP_BITSET, 16'h1f, 3'h2, 11'h0);
		q(`DS_OP_BITSET, 16'h1f, 3'h1, 11'h0);
		cmp8({7'h0, eeBusy_r}, 8'h01);
		repeat (2) @(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk) rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1 cmp8({7'h0, eeBusy_r}, 8'h01);
		repeat (24) @(posedge sys_clk);
		#1 cmp8({7'h0, eeBusy_r}, 8'h00);
		final_report;
	end
endmodule
